// ==== include/lsi_pkg.sv ====
/*
 * Constants shared by the LED signal indicator: register offsets, field
 * positions, reset values, colour and latch encodings and flash timing.
 * Assumes a 20 MHz system clock and a 32-bit Avalon-MM register bus.
 */
package lsi_pkg;
   localparam int NUM_SLOT = 5;
   localparam int SEL_W = 6;
   localparam int NUM_SIG = 32;

   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_SLOT = 4'h4;
   localparam logic [3:0] OFS_INV = 4'h8;
   localparam logic [3:0] OFS_STAT = 4'hc;

   localparam int CTRL_LATCH_LSB = 0;
   localparam int CTRL_ACT_LSB = 2;
   localparam int CTRL_INACT_LSB = 4;
   localparam int CTRL_ACK_LSB = 8;
   localparam int STAT_OR_BIT = 0;
   localparam int STAT_HELD_BIT = 1;
   localparam int STAT_RED_BIT = 2;
   localparam int STAT_GREEN_BIT = 3;
   localparam int STAT_CAUSE_LSB = 4;

   typedef enum logic [1:0] {
      COL_GREEN = 2'h0,
      COL_RED = 2'h1,
      COL_RED_FLASH = 2'h2,
      COL_GREEN_FLASH = 2'h3
   } lsi_colour_e;

   typedef enum logic [1:0] {
      LAT_NONE = 2'h0,
      LAT_PLAIN = 2'h1,
      LAT_ALARM = 2'h2
   } lsi_latch_e;

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_HELD = 1'b1
   } lsi_state_e;

   localparam logic [1:0] RST_LATCH = 2'h0;
   localparam logic [1:0] RST_ACT = 2'h1;
   localparam logic [1:0] RST_INACT = 2'h0;
   localparam logic [SEL_W-1:0] RST_SEL = 6'h00;
   localparam logic [NUM_SLOT-1:0] RST_INV = 5'h00;

   localparam longint CLK_HZ = 20000000;
   localparam longint FLASH_HALF_MS = 500;
   localparam int FLASH_CYC = int'(FLASH_HALF_MS * CLK_HZ / 1000);
endpackage

// ==== include/lsi_cfg_if.sv ====
/*
 * Carrier between the register slave and the indicator core: settings
 * flow to the core, live state flows back for the status register.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface lsi_cfg_if;
   logic [1:0] latchMode;
   logic [1:0] actColour;
   logic [1:0] inactColour;
   logic [lsi_pkg::SEL_W-1:0] ackSel;
   logic [lsi_pkg::NUM_SLOT*lsi_pkg::SEL_W-1:0] slotSel;
   logic [lsi_pkg::NUM_SLOT-1:0] invert;
   logic orNow;
   logic held;
   logic ledRed;
   logic ledGreen;
   logic [lsi_pkg::NUM_SLOT-1:0] causeMask;

   modport regs (
      output latchMode, actColour, inactColour, ackSel, slotSel, invert,
      input orNow, held, ledRed, ledGreen, causeMask
   );
   modport core (
      input latchMode, actColour, inactColour, ackSel, slotSel, invert,
      output orNow, held, ledRed, ledGreen, causeMask
   );
endinterface

// ==== logic/lsi_avalon_regs.sv ====
/*
 * Avalon-MM register slave of the LED signal indicator.
 * Assumes a master that holds its request until waitrequest is low.
 */
`timescale 1ns/1ps
module lsi_avalon_regs (
   input wire logic mclk, // system clock
   input wire logic rst_b, // async reset, active low
   input wire logic [3:0] address, // byte address
   input wire logic read, // read request
   input wire logic write, // write request
   input wire logic [3:0] byteenable, // write byte lanes
   input wire logic [31:0] writedata, // write data
   output logic [31:0] readdata, // read data
   output logic waitrequest, // stall
   lsi_cfg_if.regs cfg // settings and state
);
   logic ack_reg;
   logic [31:0] ctrl_reg;
   logic [31:0] slot_reg;
   logic [31:0] inv_reg;
   logic [31:0] rdata_reg;
   logic [31:0] status;
   logic [31:0] mask;
   logic doWrite;

   // Each access waits one cycle so read data always come from a flop.
   assign waitrequest = (read | write) & ~ack_reg;
   assign doWrite = write & ack_reg;
   assign readdata = rdata_reg;
   assign mask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                  {8{byteenable[1]}}, {8{byteenable[0]}}};

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= (read | write) & ~ack_reg;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_reg <= {18'h00000, lsi_pkg::RST_SEL, 2'h0, lsi_pkg::RST_INACT,
                      lsi_pkg::RST_ACT, lsi_pkg::RST_LATCH};
         slot_reg <= 32'h00000000;
         inv_reg <= {27'h0000000, lsi_pkg::RST_INV};
      end else if (doWrite) begin
         if (address == lsi_pkg::OFS_CTRL) begin
            ctrl_reg <= (ctrl_reg & ~mask) | (writedata & mask & 32'h00003f3f);
         end
         if (address == lsi_pkg::OFS_SLOT) begin
            slot_reg <= (slot_reg & ~mask) | (writedata & mask & 32'h3fffffff);
         end
         if (address == lsi_pkg::OFS_INV) begin
            inv_reg <= (inv_reg & ~mask) | (writedata & mask & 32'h0000001f);
         end
      end
   end

   always_comb begin
      status = 32'h00000000;
      status[lsi_pkg::STAT_OR_BIT] = cfg.orNow;
      status[lsi_pkg::STAT_HELD_BIT] = cfg.held;
      status[lsi_pkg::STAT_RED_BIT] = cfg.ledRed;
      status[lsi_pkg::STAT_GREEN_BIT] = cfg.ledGreen;
      status[lsi_pkg::STAT_CAUSE_LSB +: lsi_pkg::NUM_SLOT] = cfg.causeMask;
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_reg <= 32'h00000000;
      end else if (read & ~ack_reg) begin
         unique case (address)
            lsi_pkg::OFS_CTRL: rdata_reg <= ctrl_reg;
            lsi_pkg::OFS_SLOT: rdata_reg <= slot_reg;
            lsi_pkg::OFS_INV: rdata_reg <= inv_reg;
            lsi_pkg::OFS_STAT: rdata_reg <= status;
            default: rdata_reg <= 32'h00000000;
         endcase
      end
   end

   assign cfg.latchMode = ctrl_reg[lsi_pkg::CTRL_LATCH_LSB +: 2];
   assign cfg.actColour = ctrl_reg[lsi_pkg::CTRL_ACT_LSB +: 2];
   assign cfg.inactColour = ctrl_reg[lsi_pkg::CTRL_INACT_LSB +: 2];
   assign cfg.ackSel = ctrl_reg[lsi_pkg::CTRL_ACK_LSB +: lsi_pkg::SEL_W];
   assign cfg.slotSel = slot_reg[lsi_pkg::NUM_SLOT*lsi_pkg::SEL_W-1:0];
   assign cfg.invert = inv_reg[lsi_pkg::NUM_SLOT-1:0];
endmodule

// ==== logic/lsi_led.sv ====
/*
 * One configurable front-panel indicator LED: five selectable, optionally
 * inverted signals are ORed; the result picks the active or inactive
 * colour, with optional latching and acknowledgement.
 * Assumes signal and alarm inputs are asynchronous to mclk.
 */
// The implementer's own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module lsi_led #(
   parameter int NUM_SIG = lsi_pkg::NUM_SIG,
   parameter int FLASH_CYC = lsi_pkg::FLASH_CYC
) (
   input wire logic mclk, // system clock, 20 MHz
   input wire logic rst_b, // async reset, active low
   input wire logic [NUM_SIG-1:0] sigIn, // assignable device signals
   input wire logic alarmAck, // general alarm acknowledgement
   input wire logic [3:0] address, // Avalon byte address
   input wire logic read, // Avalon read
   input wire logic write, // Avalon write
   input wire logic [3:0] byteenable, // Avalon byte enables
   input wire logic [31:0] writedata, // Avalon write data
   output logic [31:0] readdata, // Avalon read data
   output logic waitrequest, // Avalon stall
   output logic ledRed, // red LED drive
   output logic ledGreen // green LED drive
);
   lsi_cfg_if cfg ();

   logic [NUM_SIG-1:0] sigMeta_reg;
   logic [NUM_SIG-1:0] sigSync_reg;
   logic alarmMeta_reg;
   logic alarmSync_reg;
   logic [lsi_pkg::NUM_SLOT-1:0] slotRaw;
   logic [lsi_pkg::NUM_SLOT-1:0] slotVal;
   logic orNow;
   logic ackSig;
   logic ackEff;
   logic clearOk;
   logic indication;
   logic [1:0] colour;
   logic [31:0] flashCnt_reg;
   logic flashPhase_reg;
   logic flashTick;
   lsi_pkg::lsi_state_e state_reg;
   lsi_pkg::lsi_state_e state_next;
   logic [lsi_pkg::NUM_SLOT-1:0] cause_reg;
   logic ledRed_reg;
   logic ledGreen_reg;

   lsi_avalon_regs u_regs (
      .mclk(mclk),
      .rst_b(rst_b),
      .address(address),
      .read(read),
      .write(write),
      .byteenable(byteenable),
      .writedata(writedata),
      .readdata(readdata),
      .waitrequest(waitrequest),
      .cfg(cfg)
   );

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sigMeta_reg <= '0;
         sigSync_reg <= '0;
         alarmMeta_reg <= 1'b0;
         alarmSync_reg <= 1'b0;
      end else begin
         sigMeta_reg <= sigIn;
         sigSync_reg <= sigMeta_reg;
         alarmMeta_reg <= alarmAck;
         alarmSync_reg <= alarmMeta_reg;
      end
   end

   // Selector value zero means an unassigned slot, which reads false.
   function automatic logic pick(input logic [lsi_pkg::SEL_W-1:0] sel,
                                 input logic [NUM_SIG-1:0] sig);
      logic r;
      r = 1'b0;
      for (int i = 0; i < NUM_SIG; i++) begin
         if (int'(sel) == i + 1) begin
            r = sig[i];
         end
      end
      return r;
   endfunction

   // An unassigned slot stays false even when inverted, so a spare slot
   // cannot light the LED permanently.
   always_comb begin
      for (int s = 0; s < lsi_pkg::NUM_SLOT; s++) begin
         slotRaw[s] = pick(cfg.slotSel[s*lsi_pkg::SEL_W +: lsi_pkg::SEL_W],
                           sigSync_reg);
         slotVal[s] = (cfg.slotSel[s*lsi_pkg::SEL_W +: lsi_pkg::SEL_W] != '0)
                      & (slotRaw[s] ^ cfg.invert[s]);
      end
   end

   assign orNow = |slotVal;
   assign ackSig = pick(cfg.ackSel, sigSync_reg);
   assign ackEff = (cfg.latchMode == lsi_pkg::LAT_PLAIN) ? ackSig :
                   (cfg.latchMode == lsi_pkg::LAT_ALARM) ? alarmSync_reg :
                   1'b0;
   assign clearOk = ackEff & ~|(cause_reg & slotVal);

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         lsi_pkg::ST_IDLE: begin
            if (orNow && cfg.latchMode != lsi_pkg::LAT_NONE) begin
               state_next = lsi_pkg::ST_HELD;
            end
         end
         lsi_pkg::ST_HELD: begin
            if (cfg.latchMode == lsi_pkg::LAT_NONE) begin
               state_next = lsi_pkg::ST_IDLE;
            end else if (clearOk && !orNow) begin
               state_next = lsi_pkg::ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= lsi_pkg::ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Causes gather while held; a fresh pickup wins over a clear.
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cause_reg <= '0;
      end else if (state_next == lsi_pkg::ST_IDLE) begin
         cause_reg <= '0;
      end else begin
         cause_reg <= cause_reg | slotVal;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         flashCnt_reg <= 32'h00000000;
         flashPhase_reg <= 1'b0;
      end else if (flashTick) begin
         flashCnt_reg <= 32'h00000000;
         flashPhase_reg <= ~flashPhase_reg;
      end else begin
         flashCnt_reg <= flashCnt_reg + 32'h00000001;
      end
   end
   assign flashTick = (flashCnt_reg == 32'(FLASH_CYC - 1));

   assign indication = orNow | (state_reg == lsi_pkg::ST_HELD);
   assign colour = indication ? cfg.actColour : cfg.inactColour;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ledRed_reg <= 1'b0;
         ledGreen_reg <= 1'b0;
      end else begin
         unique case (colour)
            lsi_pkg::COL_GREEN: begin
               ledRed_reg <= 1'b0;
               ledGreen_reg <= 1'b1;
            end
            lsi_pkg::COL_RED: begin
               ledRed_reg <= 1'b1;
               ledGreen_reg <= 1'b0;
            end
            lsi_pkg::COL_RED_FLASH: begin
               ledRed_reg <= flashPhase_reg;
               ledGreen_reg <= 1'b0;
            end
            lsi_pkg::COL_GREEN_FLASH: begin
               ledRed_reg <= 1'b0;
               ledGreen_reg <= flashPhase_reg;
            end
         endcase
      end
   end

   assign ledRed = ledRed_reg;
   assign ledGreen = ledGreen_reg;
   assign cfg.orNow = orNow;
   assign cfg.held = (state_reg == lsi_pkg::ST_HELD);
   assign cfg.ledRed = ledRed_reg;
   assign cfg.ledGreen = ledGreen_reg;
   assign cfg.causeMask = cause_reg;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   a_active_red: assert property (
      indication && cfg.actColour == lsi_pkg::COL_RED |=> ledRed && !ledGreen)
      else $error("active red not shown");
   a_inactive_green: assert property (
      !indication && cfg.inactColour == lsi_pkg::COL_GREEN
      |=> ledGreen && !ledRed)
      else $error("inactive green not shown");
   a_slot_invert: assert property (
      cfg.slotSel[lsi_pkg::SEL_W-1:0] != '0 && cfg.invert[0] && !slotRaw[0]
      |-> orNow)
      else $error("inverted slot did not raise the OR");
   a_latch_holds: assert property (
      cfg.latchMode != lsi_pkg::LAT_NONE && orNow
      |=> state_reg == lsi_pkg::ST_HELD)
      else $error("pickup not latched");
   a_ack_gated: assert property (
      state_reg == lsi_pkg::ST_HELD && cfg.latchMode == lsi_pkg::LAT_ALARM
      && !alarmSync_reg |=> state_reg == lsi_pkg::ST_HELD)
      else $error("latch cleared without alarm acknowledgement");
   a_cause_blocks: assert property (
      state_reg == lsi_pkg::ST_HELD && cfg.latchMode != lsi_pkg::LAT_NONE
      && (cause_reg & slotVal) != '0 |=> state_reg == lsi_pkg::ST_HELD)
      else $error("latch cleared while a cause remains");
   a_red_flash: assert property (
      indication && cfg.actColour == lsi_pkg::COL_RED_FLASH
      |=> !ledGreen && ledRed == $past(flashPhase_reg))
      else $error("red flash drive wrong");
   a_flash_rate: assert property (
      flashTick |=> flashCnt_reg == 32'h00000000
      && flashPhase_reg != $past(flashPhase_reg))
      else $error("flash phase did not toggle");
   a_flash_steady: assert property (
      !flashTick |=> flashPhase_reg == $past(flashPhase_reg))
      else $error("flash phase toggled early");

   c_latch_ack: cover property (
      state_reg == lsi_pkg::ST_HELD ##1 state_reg == lsi_pkg::ST_IDLE);
   c_flash_led: cover property (
      colour == lsi_pkg::COL_GREEN_FLASH && flashTick);
   c_ack_blocked: cover property (ackEff && !clearOk && cfg.held);
endmodule

// ==== tb/lsi_led_bench.sv ====
/*
 * Self-checking bench for the LED signal indicator: register defaults,
 * OR with inversion, colour codes, flashing, both latch modes, mid-run reset.
 * Assumes the register slave answers after one wait cycle and flash half
 * periods of FLASH_CYC clocks.
 */
`timescale 1ns/1ps
module lsi_led_bench;
   localparam int FCYC = 4;
   typedef struct {
      logic [3:0] addr;
      logic [31:0] exp;
      logic [31:0] mask;
   } lsi_note_s;
   logic mclk;
   logic rst_b;
   logic [31:0] sigIn;
   logic alarmAck;
   logic [3:0] address;
   logic read;
   logic write;
   logic [3:0] byteenable;
   logic [31:0] writedata;
   logic [31:0] readdata;
   logic waitrequest;
   logic ledRed;
   logic ledGreen;
   logic prevRed;
   logic prevGreen;
   lsi_note_s notes[$];
   lsi_note_s nt;
   int nErrors = 0;
   int numChecks = 0;
   int redTog = 0;
   int greenTog = 0;
   int cyc = 0;
   int waitCnt = 0;
   int r0;
   int g0;
   logic [4:0] inv;
   logic [31:0] sig;

   lsi_led #(.NUM_SIG(32), .FLASH_CYC(FCYC)) dut (
      .mclk(mclk), .rst_b(rst_b), .sigIn(sigIn), .alarmAck(alarmAck),
      .address(address), .read(read), .write(write),
      .byteenable(byteenable), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest),
      .ledRed(ledRed), .ledGreen(ledGreen)
   );

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   task automatic cmpWord(input string what, input logic [31:0] exp,
                          input logic [31:0] got);
      numChecks++;
      if (got !== exp) begin
         nErrors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wrapUp();
      $display("checks %0d mismatches %0d", numChecks, nErrors);
      if (nErrors == 0 && numChecks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Watches the bus: the master samples at the edge where waitrequest is
   // low, so pre-edge values seen here are exactly what it takes.
   always @(posedge mclk) begin
      if (read && !waitrequest) begin
         if (notes.size() == 0) begin
            cmpWord("unexpected read", 32'h0, 32'hffff_ffff);
         end else begin
            nt = notes.pop_front();
            cmpWord("readdata", nt.exp & nt.mask, readdata & nt.mask);
            if (nt.addr === lsi_pkg::OFS_STAT && nt.mask[2])
               cmpWord("led pins", {30'h0, nt.exp[3:2]},
                       {30'h0, ledGreen, ledRed});
         end
      end
      // The slave promises exactly one wait cycle on every access.
      if ((read || write) && waitrequest) waitCnt++;
      if ((read || write) && !waitrequest) begin
         cmpWord("wait cycles", 32'h1, waitCnt);
         waitCnt = 0;
      end
      if (rst_b && ledRed !== prevRed) redTog++;
      if (rst_b && ledGreen !== prevGreen) greenTog++;
      prevRed <= ledRed;
      prevGreen <= ledGreen;
   end

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         cmpWord("timeout", 32'h0, 32'h1);
         wrapUp();
      end
   end

   task automatic busWr(input logic [3:0] a, input logic [31:0] d,
                        input logic [3:0] be = 4'hf);
      @(posedge mclk);
      address <= a;
      writedata <= d;
      byteenable <= be;
      write <= 1'b1;
      @(posedge mclk iff !waitrequest);
      write <= 1'b0;
   endtask

   task automatic rdExp(input logic [3:0] a, input logic [31:0] e,
                        input logic [31:0] m);
      lsi_note_s n;
      n.addr = a;
      n.exp = e;
      n.mask = m;
      notes.push_back(n);
      @(posedge mclk);
      address <= a;
      read <= 1'b1;
      @(posedge mclk iff !waitrequest);
      read <= 1'b0;
   endtask

   // Two sync flops plus the LED flop; six edges leave margin.
   task automatic drive(input logic [31:0] s, input logic ack);
      @(posedge mclk);
      sigIn <= s;
      alarmAck <= ack;
      repeat (6) @(posedge mclk);
   endtask

   task automatic endTest(input string name);
      $display("test %s done, mismatches so far %0d", name, nErrors);
   endtask

   initial begin
      rst_b = 1'b0;
      sigIn = 32'h0;
      alarmAck = 1'b0;
      address = 4'h0;
      read = 1'b0;
      write = 1'b0;
      byteenable = 4'hf;
      writedata = 32'h0;
      prevRed = 1'b0;
      prevGreen = 1'b0;
      void'($urandom(36397));
      repeat (5) @(posedge mclk);
      rst_b <= 1'b1;
      rdExp(lsi_pkg::OFS_CTRL, 32'h4, 32'h3f3f);
      rdExp(lsi_pkg::OFS_SLOT, 32'h0, 32'h3fff_ffff);
      rdExp(lsi_pkg::OFS_INV, 32'h0, 32'h1f);
      rdExp(lsi_pkg::OFS_STAT, 32'h8, 32'hf);
      busWr(4'h2, 32'hffff_ffff);
      rdExp(4'h2, 32'h0, 32'hffff_ffff);
      // Only lane 1 is enabled, so the low control byte must survive.
      busWr(lsi_pkg::OFS_CTRL, 32'hffff_ffff, 4'h2);
      rdExp(lsi_pkg::OFS_CTRL, 32'h3f04, 32'h3f3f);
      endTest("defaults");
      // Unassigned slots stay false even when inverted.
      busWr(lsi_pkg::OFS_INV, 32'h1f);
      drive(32'hffff_ffff, 1'b0);
      rdExp(lsi_pkg::OFS_STAT, 32'h8, 32'hf);
      busWr(lsi_pkg::OFS_INV, 32'h0);
      busWr(lsi_pkg::OFS_SLOT, 32'h0510_3081);
      for (int s = 0; s < 5; s++) begin
         drive(32'h1 << s, 1'b0);
         rdExp(lsi_pkg::OFS_STAT, 32'h5, 32'hf);
      end
      for (int i = 0; i < 10; i++) begin
         inv = 5'($urandom);
         sig = $urandom;
         busWr(lsi_pkg::OFS_INV, {27'h0, inv});
         drive(sig, 1'b0);
         rdExp(lsi_pkg::OFS_STAT, (|(sig[4:0] ^ inv)) ? 32'h5 : 32'h8,
               32'hf);
      end
      busWr(lsi_pkg::OFS_INV, 32'h0);
      endTest("or and invert");
      for (int k = 0; k < 2; k++) begin
         for (int c = 0; c < 4; c++) begin
            busWr(lsi_pkg::OFS_CTRL, (k == 1) ? {26'h0, c[1:0], 4'h0}
                                              : {28'h0, c[1:0], 2'h0});
            drive((k == 1) ? 32'h0 : 32'h1, 1'b0);
            r0 = redTog;
            g0 = greenTog;
            repeat (10 * FCYC) @(posedge mclk);
            cmpWord("red toggling", 32'h1, {31'h0, (c == 2) ?
               (redTog - r0 >= 9 && redTog - r0 <= 11) :
               (redTog == r0)});
            cmpWord("green toggling", 32'h1, {31'h0, (c == 3) ?
               (greenTog - g0 >= 9 && greenTog - g0 <= 11) :
               (greenTog == g0)});
            if (c < 2)
               rdExp(lsi_pkg::OFS_STAT, {28'h0, c == 0, c == 1, 1'b0,
                     k == 0}, 32'hf);
         end
      end
      endTest("colours");
      // Plain latch, ack from sigIn[5] through selector value 6.
      busWr(lsi_pkg::OFS_CTRL, 32'h0000_0605);
      drive(32'h1, 1'b0);
      rdExp(lsi_pkg::OFS_STAT, 32'h7, 32'hf);
      drive(32'h0, 1'b0);
      rdExp(lsi_pkg::OFS_STAT, 32'h6, 32'hf);
      drive(32'h21, 1'b0);
      rdExp(lsi_pkg::OFS_STAT, 32'h17, 32'h1ff);
      drive(32'h0, 1'b1);
      rdExp(lsi_pkg::OFS_STAT, 32'h6, 32'hf);
      drive(32'h20, 1'b0);
      rdExp(lsi_pkg::OFS_STAT, 32'h8, 32'hf);
      drive(32'h0, 1'b0);
      endTest("plain latch");
      busWr(lsi_pkg::OFS_CTRL, 32'h0000_0606);
      drive(32'h1, 1'b0);
      drive(32'h20, 1'b0);
      rdExp(lsi_pkg::OFS_STAT, 32'h6, 32'hf);
      drive(32'h1, 1'b1);
      rdExp(lsi_pkg::OFS_STAT, 32'h7, 32'hf);
      drive(32'h0, 1'b1);
      rdExp(lsi_pkg::OFS_STAT, 32'h8, 32'hf);
      drive(32'h0, 1'b0);
      endTest("alarm latch");
      // Latch code 3 has no acknowledgement source at all.
      busWr(lsi_pkg::OFS_CTRL, 32'h0000_0607);
      drive(32'h1, 1'b0);
      drive(32'h20, 1'b1);
      rdExp(lsi_pkg::OFS_STAT, 32'h6, 32'hf);
      busWr(lsi_pkg::OFS_CTRL, 32'h0000_0604);
      drive(32'h0, 1'b0);
      rdExp(lsi_pkg::OFS_STAT, 32'h8, 32'hf);
      endTest("latch without source");
      busWr(lsi_pkg::OFS_CTRL, 32'h0000_0605);
      drive(32'h1, 1'b0);
      drive(32'h0, 1'b0);
      rdExp(lsi_pkg::OFS_STAT, 32'h6, 32'hf);
      @(posedge mclk);
      rst_b <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      rdExp(lsi_pkg::OFS_STAT, 32'h8, 32'hf);
      rdExp(lsi_pkg::OFS_CTRL, 32'h4, 32'h3f3f);
      repeat (2) @(posedge mclk);
      cmpWord("pending reads", 32'h0, notes.size());
      endTest("reset");
      wrapUp();
   end
endmodule
